/* hdl/gpm_pkg.sv */
// Constants, register map and types for the generator protection monitor
package gpm_pkg;
  // ==========================================================
  // Timing and percentage scale
  localparam int unsigned GPM_CLK_HZ       = 20_000_000;
  localparam int unsigned GPM_TICK_MS      = 1;
  localparam int unsigned GPM_TICK_CYCLES  = GPM_CLK_HZ / 1000 * GPM_TICK_MS;
  localparam logic [15:0] GPM_SEQ_FILT_MS  = 16'd500;
  localparam logic [6:0]  GPM_PCT_FULL     = 7'd100;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] GPM_CFG_OFF      = 8'h00;
  localparam logic [7:0] GPM_OIL_THR_OFF  = 8'h04;
  localparam logic [7:0] GPM_OIL_DLY_OFF  = 8'h08;
  localparam logic [7:0] GPM_VLOW_OFF     = 8'h0c;
  localparam logic [7:0] GPM_FLOW_OFF     = 8'h10;
  localparam logic [7:0] GPM_RATED_OFF    = 8'h14;
  localparam logic [7:0] GPM_STATUS_OFF   = 8'h18;
  localparam logic [7:0] GPM_MASK_OFF     = 8'h1c;
  localparam logic [7:0] GPM_LIVE_OFF     = 8'h20;

  // ==========================================================
  // Configuration word fields
  localparam int GPM_CFG_DEDIC  = 0;
  localparam int GPM_CFG_SENDER = 1;
  localparam int GPM_CFG_GENERAL = 2;
  localparam int GPM_CFG_WEEKLY = 3;
  localparam int GPM_CFG_WORK   = 4;
  localparam int GPM_CFG_MANOPT = 5;
  localparam int GPM_CFG_ENGT   = 8;
  localparam int GPM_CFG_PHASES = 16;
  localparam int GPM_CFG_ROT    = 18;
  localparam int GPM_CFG_ACT    = 20;
  localparam int GPM_MAN_BIT    = 2;

  // Status and mask bit positions and event count
  localparam int GPM_EV_OIL   = 0;
  localparam int GPM_EV_SEQW  = 1;
  localparam int GPM_EV_SEQD  = 2;
  localparam int GPM_EV_SEQA  = 3;
  localparam int GPM_EV_VLOW  = 4;
  localparam int GPM_EV_CLK   = 5;
  localparam int GPM_EV_FLOW  = 6;
  localparam int GPM_EV_W     = 7;

  localparam logic [31:0] GPM_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] GPM_ZERO     = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    GPM_MODE_OFF    = 3'b000,
    GPM_MODE_MAN    = 3'b001,
    GPM_MODE_AUTO   = 3'b010,
    GPM_MODE_TEST   = 3'b011,
    GPM_MODE_REMOTE = 3'b100
  } gpm_mode_t;

  typedef enum logic [1:0] {
    GPM_ROT_OFF   = 2'b00,
    GPM_ROT_CW    = 2'b01,
    GPM_ROT_CCW   = 2'b10,
    GPM_ROT_MAINS = 2'b11
  } gpm_rot_t;

  typedef enum logic [1:0] {
    GPM_ACT_WARN  = 2'b00,
    GPM_ACT_DEACT = 2'b01,
    GPM_ACT_ALARM = 2'b10
  } gpm_act_t;

  typedef enum logic [1:0] {
    GPM_BUS_IDLE = 2'b00,
    GPM_BUS_WR   = 2'b01,
    GPM_BUS_RD   = 2'b10,
    GPM_BUS_RDY  = 2'b11
  } gpm_bus_t;
endpackage : gpm_pkg

/* hdl/gpm_monitor.sv */
// Generator protection monitor with AHB-Lite register slave
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module gpm_monitor
  import gpm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = GPM_TICK_CYCLES
)(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Measurements and plant state
  input  wire logic [15:0] oil_temp,
  input  wire logic        oil_temp_bus_valid,
  input  wire logic [15:0] gen_volt_l1,
  input  wire logic [15:0] gen_volt_l2,
  input  wire logic [15:0] gen_volt_l3,
  input  wire logic [15:0] gen_freq,
  input  wire logic        gen_in_tol,
  input  wire logic        gen_rot_cw,
  input  wire logic        mains_rot_cw,
  input  wire logic        fuel_cmd,
  input  wire logic        eng_starting,
  input  wire logic        eng_stopping,
  input  wire logic        generator_breaker,
  input  wire logic        load_on_gen,
  input  wire logic        load_on_mains,
  input  wire logic [2:0]  op_mode,
  input  wire logic        rtc_valid,
  // Events
  output logic             oil_temp_warn,
  output logic             seq_warn,
  output logic             seq_deact,
  output logic             seq_alarm,
  output logic             low_volt_warn,
  output logic             clock_invalid_warn,
  output logic             low_freq_warn,
  output logic             irq
);
  // ==========================================================
  // Register bus
  logic [31:0] cfg_reg, oil_thr_reg, oil_dly_reg, vlow_reg, flow_reg, rated_reg;
  logic [GPM_EV_W-1:0] status_reg, mask_reg;
  gpm_bus_t    bus_reg;
  logic [7:0]  addr_reg;
  logic [31:0] rdata_mux;
  logic [GPM_EV_W-1:0] events, status_next;

  wire addr_ok  = hsel && hready && htrans[1];
  wire wr_phase = (bus_reg == GPM_BUS_WR);
  wire wr_cfg   = wr_phase && (addr_reg == GPM_CFG_OFF);
  wire wr_othr  = wr_phase && (addr_reg == GPM_OIL_THR_OFF);
  wire wr_odly  = wr_phase && (addr_reg == GPM_OIL_DLY_OFF);
  wire wr_vlow  = wr_phase && (addr_reg == GPM_VLOW_OFF);
  wire wr_flow  = wr_phase && (addr_reg == GPM_FLOW_OFF);
  wire wr_rated = wr_phase && (addr_reg == GPM_RATED_OFF);
  wire wr_stat  = wr_phase && (addr_reg == GPM_STATUS_OFF);
  wire wr_mask  = wr_phase && (addr_reg == GPM_MASK_OFF);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bus_reg  <= GPM_BUS_IDLE;
      addr_reg <= 8'h00;
    end
    else if (bus_reg == GPM_BUS_RD)
      bus_reg <= GPM_BUS_RDY;
    else
    begin
      bus_reg  <= !addr_ok ? GPM_BUS_IDLE : (hwrite ? GPM_BUS_WR : GPM_BUS_RD);
      addr_reg <= addr_ok ? haddr[7:0] : addr_reg;
    end

  // Reads take one wait state so hrdata comes from a flop after any write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hrdata    <= GPM_ZERO;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= !(addr_ok && !hwrite && bus_reg != GPM_BUS_RD);
      hrdata    <= (bus_reg == GPM_BUS_RD) ? rdata_mux : GPM_ZERO;
      hresp     <= 1'b0;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cfg_reg     <= GPM_CFG_RST;
      oil_thr_reg <= GPM_ZERO;
      oil_dly_reg <= GPM_ZERO;
      vlow_reg    <= GPM_ZERO;
      flow_reg    <= GPM_ZERO;
      rated_reg   <= GPM_ZERO;
      mask_reg    <= '0;
    end
    else
    begin
      cfg_reg     <= wr_cfg   ? hwdata : cfg_reg;
      oil_thr_reg <= wr_othr  ? {16'h0000, hwdata[15:0]} : oil_thr_reg;
      oil_dly_reg <= wr_odly  ? hwdata : oil_dly_reg;
      vlow_reg    <= wr_vlow  ? {hwdata[31:16], 9'h000, hwdata[6:0]} : vlow_reg;
      flow_reg    <= wr_flow  ? {hwdata[31:16], 9'h000, hwdata[6:0]} : flow_reg;
      rated_reg   <= wr_rated ? hwdata : rated_reg;
      mask_reg    <= wr_mask  ? hwdata[GPM_EV_W-1:0] : mask_reg;
    end

  // ==========================================================
  // Qualification
  wire [7:0]  engine_type = cfg_reg[GPM_CFG_ENGT +: 8];
  wire [1:0]  phases      = cfg_reg[GPM_CFG_PHASES +: 2];
  wire [1:0]  rot_req     = cfg_reg[GPM_CFG_ROT +: 2];
  wire [1:0]  seq_act     = cfg_reg[GPM_CFG_ACT +: 2];
  wire [15:0] oil_mask_ms = oil_dly_reg[31:16];
  wire mode_ok   = (op_mode == GPM_MODE_MAN) || (op_mode == GPM_MODE_AUTO) ||
                   (op_mode == GPM_MODE_TEST) || (op_mode == GPM_MODE_REMOTE);
  wire run_ok    = fuel_cmd && !eng_starting && !eng_stopping && mode_ok;
  wire man_ok    = (op_mode != GPM_MODE_MAN) || generator_breaker ||
                   cfg_reg[GPM_CFG_MANOPT + GPM_MAN_BIT];
  wire bus_oil   = oil_temp_bus_valid && (engine_type != 8'h00);
  wire oil_armed = cfg_reg[GPM_CFG_DEDIC] || cfg_reg[GPM_CFG_SENDER] ||
                   cfg_reg[GPM_CFG_GENERAL] || bus_oil;

  // ==========================================================
  // Millisecond tick and oil mask timer
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic [15:0] mask_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tick_cnt_reg <= GPM_ZERO;
      tick_reg     <= 1'b0;
      mask_cnt_reg <= 16'h0000;
    end
    else
    begin
      tick_reg     <= (tick_cnt_reg == TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == TICK_CYCLES - 1) ? GPM_ZERO : tick_cnt_reg + 32'h1;
      if (!run_ok)
        mask_cnt_reg <= 16'h0000;
      else if (tick_reg && mask_cnt_reg != 16'hffff)
        mask_cnt_reg <= mask_cnt_reg + 16'h0001;
    end
  wire mask_done = run_ok && (mask_cnt_reg >= oil_mask_ms);

  // ==========================================================
  // Threshold comparisons
  logic [23:0] vlim, flim;
  logic [2:0]  vbelow;
  assign vlim = 24'(rated_reg[15:0]) * 24'(vlow_reg[6:0]);
  assign flim = 24'(rated_reg[31:16]) * 24'(flow_reg[6:0]);
  wire [15:0] vph [3] = '{gen_volt_l1, gen_volt_l2, gen_volt_l3};
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++)
    begin : g_phase
      // Only phases that exist take part
      assign vbelow[gp] = (2'(gp) < phases) && ((24'(vph[gp]) * 24'(GPM_PCT_FULL)) < vlim);
    end
  endgenerate
  wire fbelow    = (24'(gen_freq) * 24'(GPM_PCT_FULL)) < flim;
  wire rot_want  = (rot_req == GPM_ROT_MAINS) ? mains_rot_cw : (rot_req == GPM_ROT_CW);
  wire seq_armed = run_ok && (phases == 2'd2 || phases == 2'd3) &&
                   (rot_req != GPM_ROT_OFF) && gen_in_tol && load_on_mains;

  // ==========================================================
  // Persistence timers: oil, sequence, voltage, frequency
  logic [3:0]  tcond, tfire;
  logic [15:0] tdly [4];
  logic [15:0] tcnt_reg [4];
  assign tcond[0] = oil_armed && mask_done && (oil_temp > oil_thr_reg[15:0]);
  assign tcond[1] = seq_armed && (gen_rot_cw != rot_want);
  assign tcond[2] = run_ok && man_ok && gen_in_tol && load_on_gen && |vbelow;
  assign tcond[3] = run_ok && man_ok && gen_in_tol && load_on_gen && fbelow;
  assign tdly[0]  = oil_dly_reg[15:0];
  assign tdly[1]  = GPM_SEQ_FILT_MS;
  assign tdly[2]  = vlow_reg[31:16];
  assign tdly[3]  = flow_reg[31:16];
  genvar gt;
  generate
    for (gt = 0; gt < 4; gt++)
    begin : g_timer
      always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
          tcnt_reg[gt] <= 16'h0000;
        else if (!tcond[gt])
          tcnt_reg[gt] <= 16'h0000;
        else if (tick_reg && tcnt_reg[gt] < tdly[gt])
          tcnt_reg[gt] <= tcnt_reg[gt] + 16'h0001;
      // Zero delay disables the protection
      assign tfire[gt] = tcond[gt] && (tdly[gt] != 16'h0000) && (tcnt_reg[gt] >= tdly[gt]);
    end
  endgenerate

  // ==========================================================
  // Event outputs, status and interrupt
  wire clk_bad = !rtc_valid && (cfg_reg[GPM_CFG_WEEKLY] || cfg_reg[GPM_CFG_WORK]);
  assign events = {tfire[3], clk_bad, tfire[2],
                   tfire[1] && seq_act[1],
                   tfire[1] && (seq_act == GPM_ACT_DEACT),
                   tfire[1] && (seq_act == GPM_ACT_WARN),
                   tfire[0]};
  // Hardware set wins over a software clear in the same cycle
  assign status_next = (status_reg & ~(wr_stat ? hwdata[GPM_EV_W-1:0] : '0)) | events;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      status_reg         <= '0;
      irq                <= 1'b0;
      oil_temp_warn      <= 1'b0;
      seq_warn           <= 1'b0;
      seq_deact          <= 1'b0;
      seq_alarm          <= 1'b0;
      low_volt_warn      <= 1'b0;
      clock_invalid_warn <= 1'b0;
      low_freq_warn      <= 1'b0;
    end
    else
    begin
      status_reg         <= status_next;
      irq                <= |(status_next & mask_reg);
      oil_temp_warn      <= events[GPM_EV_OIL];
      seq_warn           <= events[GPM_EV_SEQW];
      seq_deact          <= events[GPM_EV_SEQD];
      seq_alarm          <= events[GPM_EV_SEQA];
      low_volt_warn      <= events[GPM_EV_VLOW];
      clock_invalid_warn <= events[GPM_EV_CLK];
      low_freq_warn      <= events[GPM_EV_FLOW];
    end

  always_comb
  begin
    case (addr_reg)
      GPM_CFG_OFF:     rdata_mux = cfg_reg;
      GPM_OIL_THR_OFF: rdata_mux = oil_thr_reg;
      GPM_OIL_DLY_OFF: rdata_mux = oil_dly_reg;
      GPM_VLOW_OFF:    rdata_mux = vlow_reg;
      GPM_FLOW_OFF:    rdata_mux = flow_reg;
      GPM_RATED_OFF:   rdata_mux = rated_reg;
      GPM_STATUS_OFF:  rdata_mux = {25'h0, status_reg};
      GPM_MASK_OFF:    rdata_mux = {25'h0, mask_reg};
      GPM_LIVE_OFF:    rdata_mux = {23'h0, tcond, run_ok, mask_done, seq_armed, events[GPM_EV_CLK], oil_armed};
      default:         rdata_mux = GPM_ZERO;
    endcase
  end

  // ==========================================================
  // Checks
  property p_oil_src;
    @(posedge hclk) disable iff (!hresetn) $rose(oil_temp_warn) |-> $past(oil_armed);
  endproperty
  a_oil_src: assert property (p_oil_src) else $error("oil warning without source");

  property p_bus_oil;
    @(posedge hclk) disable iff (!hresetn)
      oil_temp_warn && $past(cfg_reg[2:0] == 3'b000) |-> $past(engine_type != 8'h00);
  endproperty
  a_bus_oil: assert property (p_bus_oil) else $error("bus oil used with zero engine type");

  property p_oil_mask;
    @(posedge hclk) disable iff (!hresetn)
      $rose(oil_temp_warn) |-> $past(mask_cnt_reg >= oil_mask_ms) && $past(tdly[0] != 16'h0000);
  endproperty
  a_oil_mask: assert property (p_oil_mask) else $error("oil warning inside mask or disabled");

  property p_run_drop;
    @(posedge hclk) disable iff (!hresetn) !run_ok |=> !oil_temp_warn && !low_volt_warn && !seq_warn;
  endproperty
  a_run_drop: assert property (p_run_drop) else $error("engine protection active while not running");

  property p_seq_phases;
    @(posedge hclk) disable iff (!hresetn)
      (seq_warn || seq_deact || seq_alarm) |-> $past(phases == 2'd2 || phases == 2'd3);
  endproperty
  a_seq_phases: assert property (p_seq_phases) else $error("sequence check on wrong phase count");

  property p_seq_off;
    @(posedge hclk) disable iff (!hresetn) rot_req == GPM_ROT_OFF |=> !(seq_warn || seq_deact || seq_alarm);
  endproperty
  a_seq_off: assert property (p_seq_off) else $error("sequence raised while disabled");

  property p_seq_filter;
    @(posedge hclk) disable iff (!hresetn)
      $rose(seq_warn || seq_deact || seq_alarm) |-> $past(tcnt_reg[1]) == GPM_SEQ_FILT_MS;
  endproperty
  a_seq_filter: assert property (p_seq_filter) else $error("sequence filter time wrong");

  property p_seq_onehot;
    @(posedge hclk) disable iff (!hresetn) $onehot0({seq_warn, seq_deact, seq_alarm});
  endproperty
  a_seq_onehot: assert property (p_seq_onehot) else $error("more than one sequence action");

  property p_man_gate;
    @(posedge hclk) disable iff (!hresetn)
      (low_volt_warn || low_freq_warn) && $past(op_mode == GPM_MODE_MAN) |->
        $past(generator_breaker || cfg_reg[GPM_CFG_MANOPT + GPM_MAN_BIT]);
  endproperty
  a_man_gate: assert property (p_man_gate) else $error("manual mode gate ignored");

  property p_clk_inv;
    @(posedge hclk) disable iff (!hresetn) rtc_valid |=> !clock_invalid_warn;
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("clock invalid held after clock set");

  property p_restart;
    @(posedge hclk) disable iff (!hresetn) !tcond[2] |=> tcnt_reg[2] == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_seq_mains;
    @(posedge hclk) disable iff (!hresetn)
      !(load_on_mains && gen_in_tol) |=> !(seq_warn || seq_deact || seq_alarm);
  endproperty
  a_seq_mains: assert property (p_seq_mains) else $error("sequence raised off mains");

  property p_vlow_load;
    @(posedge hclk) disable iff (!hresetn)
      !(load_on_gen && gen_in_tol) |=> !low_volt_warn;
  endproperty
  a_vlow_load: assert property (p_vlow_load) else $error("low voltage raised off generator");

  property p_freq_off;
    @(posedge hclk) disable iff (!hresetn)
      tdly[3] == 16'h0000 |=> !low_freq_warn;
  endproperty
  a_freq_off: assert property (p_freq_off) else $error("low frequency raised while disabled");
endmodule : gpm_monitor
`default_nettype wire

/* verif/gpm_plant.sv */
// Behavioural engine and generator plant feeding the protection monitor
`timescale 1ns/10ps
`default_nettype none
module gpm_plant
  import gpm_pkg::*;
(
  // Clock
  input  wire logic        hclk,
  // Measurements toward the monitor
  output logic      [15:0] oil_temp,
  output logic             oil_temp_bus_valid,
  output logic      [15:0] gen_volt_l1,
  output logic      [15:0] gen_volt_l2,
  output logic      [15:0] gen_volt_l3,
  output logic      [15:0] gen_freq,
  output logic             gen_in_tol,
  output logic             gen_rot_cw,
  output logic             mains_rot_cw,
  // Engine, breaker and operator state
  output logic             fuel_cmd,
  output logic             eng_starting,
  output logic             eng_stopping,
  output logic             generator_breaker,
  output logic             load_on_gen,
  output logic             load_on_mains,
  output logic      [2:0]  op_mode,
  output logic             rtc_valid
);
  initial
  begin
    {oil_temp, oil_temp_bus_valid, gen_volt_l1, gen_volt_l2, gen_volt_l3, gen_freq} = '0;
    {gen_in_tol, gen_rot_cw, mains_rot_cw, fuel_cmd, eng_starting, eng_stopping} = '0;
    {generator_breaker, load_on_gen, load_on_mains, op_mode} = '0;
    rtc_valid = 1'b1;
  end

  // ==========================================================
  // Engine start and stop, with a cranking phase of chosen length
  task automatic crank(input logic [2:0] mode, input int n);
    @(posedge hclk);
    op_mode      <= mode;
    fuel_cmd     <= 1'b1;
    eng_starting <= 1'b1;
    repeat (n) @(posedge hclk);
    eng_starting <= 1'b0;
  endtask : crank

  task automatic stop(input int n);
    @(posedge hclk);
    fuel_cmd     <= 1'b0;
    eng_stopping <= 1'b1;
    repeat (n) @(posedge hclk);
    eng_stopping <= 1'b0;
  endtask : stop

  task automatic mode(input logic [2:0] m);
    @(posedge hclk);
    op_mode <= m;
  endtask : mode

  // ==========================================================
  // Measurements; the load sits on one source at a time
  task automatic oil(input logic [15:0] t, input logic bus);
    @(posedge hclk);
    oil_temp           <= t;
    oil_temp_bus_valid <= bus;
  endtask : oil

  task automatic gen(input logic [15:0] v, v3, f, input logic tol, on_gen, brk);
    @(posedge hclk);
    gen_volt_l1       <= v;
    gen_volt_l2       <= v;
    gen_volt_l3       <= v3;
    gen_freq          <= f;
    gen_in_tol        <= tol;
    load_on_gen       <= on_gen;
    load_on_mains     <= !on_gen;
    generator_breaker <= brk;
  endtask : gen

  task automatic rot(input logic g, m);
    @(posedge hclk);
    gen_rot_cw   <= g;
    mains_rot_cw <= m;
  endtask : rot

  // Operator setting the clock makes its status valid
  task automatic clk_set(input logic v);
    @(posedge hclk);
    rtc_valid <= v;
  endtask : clk_set
endmodule : gpm_plant
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the generator protection monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpm_pkg::*;
  localparam int TK = 4;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        [1:0] htrans;
  logic        [2:0] hsize;
  logic       [31:0] haddr, hwdata, hrdata;
  logic              oil_temp_warn, seq_warn, seq_deact, seq_alarm, low_volt_warn, clock_invalid_warn, low_freq_warn;
  wire  logic [15:0] oil_temp, gen_volt_l1, gen_volt_l2, gen_volt_l3, gen_freq;
  wire  logic        oil_temp_bus_valid, gen_in_tol, gen_rot_cw, mains_rot_cw, fuel_cmd, eng_starting;
  wire  logic        eng_stopping, generator_breaker, load_on_gen, load_on_mains, rtc_valid;
  wire  logic  [2:0] op_mode;
  wire  logic  [6:0] ev;
  int                n_errors = 0;
  int                num_checks = 0;

  assign ev = {low_freq_warn, clock_invalid_warn, low_volt_warn, seq_alarm, seq_deact, seq_warn, oil_temp_warn};

  gpm_monitor #(.TICK_CYCLES(TK)) i_gpm_monitor (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .oil_temp, .oil_temp_bus_valid, .gen_volt_l1, .gen_volt_l2, .gen_volt_l3,
    .gen_freq, .gen_in_tol, .gen_rot_cw, .mains_rot_cw, .fuel_cmd, .eng_starting, .eng_stopping,
    .generator_breaker, .load_on_gen, .load_on_mains, .op_mode, .rtc_valid, .oil_temp_warn, .seq_warn,
    .seq_deact, .seq_alarm, .low_volt_warn, .clock_invalid_warn, .low_freq_warn, .irq);

  gpm_plant i_gpm_plant (
    .hclk, .oil_temp, .oil_temp_bus_valid, .gen_volt_l1, .gen_volt_l2, .gen_volt_l3, .gen_freq,
    .gen_in_tol, .gen_rot_cw, .mains_rot_cw, .fuel_cmd, .eng_starting, .eng_stopping,
    .generator_breaker, .load_on_gen, .load_on_mains, .op_mode, .rtc_valid);

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Master holds each phase until hready is sampled high at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] t;
    bus(1'b0, a, 32'h0, t);
    chk(t, exp, msg);
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask : rchk

  // Event must stay low a tick short of the delay, then be up within four ticks more
  task automatic fire(input int b, input int ms, input string msg);
    repeat ((ms - 1) * TK) @(posedge hclk);
    chk({31'h0, ev[b]}, 32'h0, msg);
    repeat (4 * TK) @(posedge hclk);
    chk({31'h0, ev[b]}, 32'h1, msg);
  endtask : fire

  task automatic quiet(input int b, input int ms, input string msg);
    repeat (ms * TK) @(posedge hclk);
    chk({31'h0, ev[b]}, 32'h0, msg);
  endtask : quiet

  initial
  begin
    repeat (90000) @(posedge hclk);
    n_errors++;
    end_of_test();
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (4) @(posedge hclk);
    chk({31'h0, hreadyout}, 32'h1, "ready in reset");
    hresetn <= 1'b1;
    rchk(GPM_CFG_OFF, 32'h0, "cfg reset");
    rchk(GPM_STATUS_OFF, 32'h0, "status reset");
    rchk(GPM_MASK_OFF, 32'h0, "mask reset");
    wr(8'h40, 32'hffff_ffff);
    rchk(8'h40, 32'h0, "unmapped");
    // Oil temperature: source, engine type, mask, start phase
    wr(GPM_OIL_THR_OFF, 32'h0000_0064);
    wr(GPM_OIL_DLY_OFF, {16'd3, 16'd2});
    wr(GPM_CFG_OFF, {16'h0, 8'h01, 8'h00});
    i_gpm_plant.oil(16'd101, 1'b0);
    i_gpm_plant.crank(GPM_MODE_AUTO, 8);
    quiet(0, 8, "oil without source");
    i_gpm_plant.oil(16'd101, 1'b1);
    fire(0, 2, "oil from bus");
    wr(GPM_CFG_OFF, 32'h0);
    quiet(0, 6, "oil bus engine type zero");
    i_gpm_plant.oil(16'd101, 1'b0);
    i_gpm_plant.stop(4);
    wr(GPM_CFG_OFF, 32'h0000_0001);
    i_gpm_plant.crank(GPM_MODE_AUTO, 10 * TK);
    fire(0, 5, "oil after mask");
    i_gpm_plant.stop(TK);
    chk({31'h0, ev[0]}, 32'h0, "oil while stopping");
    i_gpm_plant.crank(GPM_MODE_AUTO, 2);
    i_gpm_plant.oil(16'd100, 1'b0);
    quiet(0, 8, "oil at threshold");
    // Phase sequence: each rotation request and action
    i_gpm_plant.gen(16'd1000, 16'd1000, 16'd500, 1'b1, 1'b0, 1'b0);
    for (int r = 0; r < 4; r++)
    begin
      i_gpm_plant.rot(r != 2, 1'b1);
      wr(GPM_CFG_OFF, {10'h0, 2'(r > 0 ? r - 1 : 0), 2'(r), 2'd3, 16'h0});
      i_gpm_plant.rot(r == 2, 1'b1);
      if (r == 0)
        quiet(1, 510, "rotation off");
      else
        fire(r, 500, "rotation mismatch");
    end
    wr(GPM_CFG_OFF, {10'h0, 2'd2, 2'd3, 2'd1, 16'h0});
    quiet(3, 510, "one phase");
    i_gpm_plant.gen(16'd1000, 16'd1000, 16'd500, 1'b1, 1'b1, 1'b1);
    wr(GPM_CFG_OFF, {10'h0, 2'd2, 2'd3, 2'd2, 16'h0});
    quiet(3, 510, "load on generator");
    i_gpm_plant.gen(16'd1000, 16'd1000, 16'd500, 1'b1, 1'b0, 1'b0);
    fire(3, 500, "two phases");
    // Low voltage: threshold, restart, manual mode
    wr(GPM_CFG_OFF, {14'h0, 2'd3, 16'h0});
    wr(GPM_RATED_OFF, {16'd500, 16'd1000});
    wr(GPM_VLOW_OFF, {16'd3, 9'h0, 7'd80});
    i_gpm_plant.gen(16'd1000, 16'd800, 16'd500, 1'b1, 1'b1, 1'b1);
    quiet(4, 6, "volt at threshold");
    i_gpm_plant.gen(16'd1000, 16'd799, 16'd500, 1'b1, 1'b1, 1'b1);
    fire(4, 3, "volt low");
    i_gpm_plant.gen(16'd1000, 16'd800, 16'd500, 1'b1, 1'b1, 1'b1);
    quiet(4, 1, "volt recovered");
    i_gpm_plant.gen(16'd1000, 16'd799, 16'd500, 1'b1, 1'b1, 1'b1);
    repeat (2 * TK) @(posedge hclk);
    i_gpm_plant.gen(16'd1000, 16'd800, 16'd500, 1'b1, 1'b1, 1'b1);
    i_gpm_plant.gen(16'd1000, 16'd799, 16'd500, 1'b1, 1'b1, 1'b1);
    fire(4, 3, "volt timer restart");
    i_gpm_plant.mode(GPM_MODE_MAN);
    i_gpm_plant.gen(16'd1000, 16'd799, 16'd500, 1'b1, 1'b1, 1'b0);
    quiet(4, 6, "manual breaker open");
    wr(GPM_CFG_OFF, {14'h0, 2'd3, 16'h0080});
    fire(4, 3, "manual option bit");
    wr(GPM_CFG_OFF, {14'h0, 2'd3, 16'h0});
    i_gpm_plant.gen(16'd1000, 16'd799, 16'd500, 1'b1, 1'b1, 1'b1);
    fire(4, 3, "manual breaker closed");
    // Low frequency across operating modes
    i_gpm_plant.gen(16'd1000, 16'd800, 16'd450, 1'b1, 1'b1, 1'b1);
    wr(GPM_FLOW_OFF, {16'd2, 9'h0, 7'd90});
    quiet(6, 5, "freq at threshold");
    for (int m = 2; m < 5; m++)
    begin
      i_gpm_plant.mode(3'(m));
      i_gpm_plant.gen(16'd1000, 16'd800, 16'd449, 1'b1, 1'b1, 1'b1);
      fire(6, 2, "freq low");
      i_gpm_plant.gen(16'd1000, 16'd800, 16'd450, 1'b1, 1'b1, 1'b1);
      repeat (TK) @(posedge hclk);
    end
    i_gpm_plant.mode(GPM_MODE_OFF);
    i_gpm_plant.gen(16'd1000, 16'd800, 16'd449, 1'b1, 1'b1, 1'b1);
    quiet(6, 5, "freq mode off");
    i_gpm_plant.mode(GPM_MODE_AUTO);
    wr(GPM_FLOW_OFF, {16'd0, 9'h0, 7'd90});
    quiet(6, 5, "freq zero delay");
    // Clock invalid with status, mask and interrupt
    i_gpm_plant.stop(4);
    wr(GPM_STATUS_OFF, 32'h0000_007f);
    rchk(GPM_STATUS_OFF, 32'h0, "status cleared");
    i_gpm_plant.clk_set(1'b0);
    for (int k = 0; k < 3; k++)
    begin
      wr(GPM_CFG_OFF, {24'h0, (k == 0) ? 8'h00 : (k == 1) ? 8'h10 : 8'h08});
      repeat (3) @(posedge hclk);
      chk({31'h0, ev[5]}, {31'h0, k != 0}, "clock invalid");
    end
    rchk(GPM_LIVE_OFF, 32'h0000_0002, "live clock bad");
    rchk(GPM_STATUS_OFF, 32'h0000_0020, "status clock");
    wr(GPM_MASK_OFF, 32'h0000_0020);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(GPM_MASK_OFF, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(GPM_MASK_OFF, 32'h0000_0020);
    i_gpm_plant.clk_set(1'b1);
    repeat (3) @(posedge hclk);
    chk({31'h0, ev[5]}, 32'h0, "clock set");
    chk({31'h0, irq}, 32'h1, "irq sticky");
    wr(GPM_STATUS_OFF, 32'h0000_0020);
    rchk(GPM_STATUS_OFF, 32'h0, "status w1c");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
